// ### verilog/cursor_draw_cfg.svh
// Register offsets, field positions and reset values of the cursor and draw group.
// Assumes the 8-bit host register port with one-cycle read latency.
`ifndef CURSOR_DRAW_CFG_SVH
`define CURSOR_DRAW_CFG_SVH

`define CDR_ADDR_W 8
`define CDR_OFS_HORIZ_LOW 8'h5f
`define CDR_OFS_HORIZ_HIGH 8'h60
`define CDR_OFS_VERT_LOW 8'h61
`define CDR_OFS_VERT_HIGH 8'h62
`define CDR_OFS_TXT_X_LOW 8'h63
`define CDR_OFS_TXT_X_HIGH 8'h64
`define CDR_OFS_TXT_Y_LOW 8'h65
`define CDR_OFS_TXT_Y_HIGH 8'h66
`define CDR_OFS_DRAW_CTRL 8'h67
`define CDR_OFS_MODE 8'h70
`define CDR_OFS_INT_STAT 8'h71
`define CDR_OFS_INT_MASK 8'h72

`define CDR_RST_BYTE 8'h00
`define CDR_MODE_LINEAR_BIT 2
`define CDR_DRAW_START_BIT 7
`define CDR_DRAW_FILL_BIT 5
`define CDR_DRAW_SHAPE_BIT 1
`define CDR_HI_MASK 8'h1f
`define CDR_MODE_MASK 8'h07
`define CDR_DRAW_MASK 8'h22
`define CDR_INT_MASK_BITS 8'h01
`define CDR_COORD_W 13

`endif

// ### verilog/cursor_draw_pkg.sv
// Types shared by the cursor and draw register group.
// Assumes cursor_draw_cfg.svh supplies all numeric constants.
`include "cursor_draw_cfg.svh"
package cursor_draw_pkg;
  typedef enum logic [1:0] {
    DRAW_IDLE = 2'b00,
    DRAW_BUSY = 2'b01
  } draw_state_t;

  typedef struct packed {
    logic fill;
    logic triangle;
  } draw_cmd_t;

  typedef struct packed {
    logic [`CDR_COORD_W-1:0] x;
    logic [`CDR_COORD_W-1:0] y;
  } coord_t;
endpackage : cursor_draw_pkg

// ### verilog/cursor_draw_regs.sv
// Graphic position, text cursor and line/triangle draw control registers.
// Assumes synchronous host port inputs and an external draw engine and text writer.
//
// Functional notes
// - Mode bit 2: zero selects block X-Y, one selects linear byte address.
// - Linear address bits 7..0 come from the low horizontal register.
// - Linear address bits 15..13 and 12..8 come from high horizontal bits 7-5, 4-0.
// - Linear address bits 23..16 come from the low vertical register.
// - Linear address bits 31..29 come from high vertical bits 7-5.
// - Linear address bits 28..24 come from high vertical bits 4-0.
// - Block mode ignores high horizontal bits 7-5; bits 4-0 form X 12..8.
// - Block mode Y is low vertical plus high vertical bits 4-0.
// - Text cursor writes set position; reads return live updated position.
// - Text cursor X is 13 bits across low and high registers.
// - Text cursor Y is 13 bits across low and high registers.
// - Writing draw bit 7 one starts drawing; zero stops it.
// - Draw bit 7 reads one while drawing, zero once done.
// - Draw bit 5 selects triangle fill.
// - Draw bit 1 selects line or triangle.
`timescale 1ns/1ps
`include "cursor_draw_cfg.svh"
module cursor_draw_regs
  import cursor_draw_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [`CDR_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic linear_mode,
  output logic [31:0] mem_addr,
  output coord_t gfx_pos,
  output coord_t text_pos,
  input wire logic text_adv,
  input wire coord_t text_pos_new,
  output logic draw_start,
  output logic draw_stop,
  output draw_cmd_t draw_cmd,
  input wire logic draw_done,
  output logic draw_busy,
  output logic irq
);

  // ****************************************************************
  // Register decode
  // ****************************************************************
  function automatic logic hit(input logic [`CDR_ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic [7:0] horiz_low_reg, horiz_high_reg, vert_low_reg, vert_high_reg;
  logic [7:0] mode_reg, int_stat_reg, int_mask_reg;
  logic [7:0] txt_x_low_reg, txt_x_high_reg, txt_y_low_reg, txt_y_high_reg;
  logic fill_reg, triangle_reg;
  draw_state_t state_reg, state_next;

  wire wr_hl = reg_wr && hit(reg_addr, `CDR_OFS_HORIZ_LOW);
  wire wr_hh = reg_wr && hit(reg_addr, `CDR_OFS_HORIZ_HIGH);
  wire wr_vl = reg_wr && hit(reg_addr, `CDR_OFS_VERT_LOW);
  wire wr_vh = reg_wr && hit(reg_addr, `CDR_OFS_VERT_HIGH);
  wire wr_xl = reg_wr && hit(reg_addr, `CDR_OFS_TXT_X_LOW);
  wire wr_xh = reg_wr && hit(reg_addr, `CDR_OFS_TXT_X_HIGH);
  wire wr_yl = reg_wr && hit(reg_addr, `CDR_OFS_TXT_Y_LOW);
  wire wr_yh = reg_wr && hit(reg_addr, `CDR_OFS_TXT_Y_HIGH);
  wire wr_dc = reg_wr && hit(reg_addr, `CDR_OFS_DRAW_CTRL);
  wire wr_md = reg_wr && hit(reg_addr, `CDR_OFS_MODE);
  wire wr_is = reg_wr && hit(reg_addr, `CDR_OFS_INT_STAT);
  wire wr_im = reg_wr && hit(reg_addr, `CDR_OFS_INT_MASK);

  wire start_req = wr_dc && reg_wdata[`CDR_DRAW_START_BIT];
  wire stop_req = wr_dc && !reg_wdata[`CDR_DRAW_START_BIT];

  // ****************************************************************
  // Position mapping
  // ****************************************************************
  wire mode_linear = mode_reg[`CDR_MODE_LINEAR_BIT];
  wire [31:0] lin_addr = {vert_high_reg[7:5], vert_high_reg[4:0],
                          vert_low_reg,
                          horiz_high_reg[7:5], horiz_high_reg[4:0],
                          horiz_low_reg};
  // High bits 7-5 drop out in block mode
  wire [`CDR_COORD_W-1:0] blk_x = {horiz_high_reg[4:0], horiz_low_reg};
  wire [`CDR_COORD_W-1:0] blk_y = {vert_high_reg[4:0], vert_low_reg};

  // ****************************************************************
  // Draw sequencing
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      DRAW_IDLE: if (start_req) state_next = DRAW_BUSY;
      DRAW_BUSY: if (stop_req || draw_done) state_next = DRAW_IDLE;
      default: state_next = DRAW_IDLE;
    endcase
  end

  wire busy_now = (state_reg == DRAW_BUSY);
  wire done_evt = busy_now && draw_done;
  wire [7:0] stat_set = {7'h00, done_evt};
  wire [7:0] stat_clr = wr_is ? (reg_wdata & `CDR_INT_MASK_BITS) : `CDR_RST_BYTE;
  // Set wins over a clear in the same cycle
  wire [7:0] int_stat_next = (int_stat_reg & ~stat_clr) | stat_set;

  // ****************************************************************
  // Read mux
  // ****************************************************************
  logic [7:0] rd_mux;
  wire [7:0] draw_rd = {busy_now, 1'b0, fill_reg, 3'b000, triangle_reg, 1'b0};
  always_comb begin
    case (reg_addr)
      `CDR_OFS_HORIZ_LOW: rd_mux = horiz_low_reg;
      `CDR_OFS_HORIZ_HIGH: rd_mux = horiz_high_reg;
      `CDR_OFS_VERT_LOW: rd_mux = vert_low_reg;
      `CDR_OFS_VERT_HIGH: rd_mux = vert_high_reg;
      `CDR_OFS_TXT_X_LOW: rd_mux = txt_x_low_reg;
      `CDR_OFS_TXT_X_HIGH: rd_mux = txt_x_high_reg & `CDR_HI_MASK;
      `CDR_OFS_TXT_Y_LOW: rd_mux = txt_y_low_reg;
      `CDR_OFS_TXT_Y_HIGH: rd_mux = txt_y_high_reg & `CDR_HI_MASK;
      `CDR_OFS_DRAW_CTRL: rd_mux = draw_rd;
      `CDR_OFS_MODE: rd_mux = mode_reg;
      `CDR_OFS_INT_STAT: rd_mux = int_stat_reg;
      `CDR_OFS_INT_MASK: rd_mux = int_mask_reg;
      default: rd_mux = `CDR_RST_BYTE;
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      horiz_low_reg <= `CDR_RST_BYTE;
      horiz_high_reg <= `CDR_RST_BYTE;
      vert_low_reg <= `CDR_RST_BYTE;
      vert_high_reg <= `CDR_RST_BYTE;
      mode_reg <= `CDR_RST_BYTE;
      int_mask_reg <= `CDR_RST_BYTE;
      int_stat_reg <= `CDR_RST_BYTE;
    end else begin
      if (wr_hl) horiz_low_reg <= reg_wdata;
      if (wr_hh) horiz_high_reg <= reg_wdata;
      if (wr_vl) vert_low_reg <= reg_wdata;
      if (wr_vh) vert_high_reg <= reg_wdata;
      if (wr_md) mode_reg <= reg_wdata & `CDR_MODE_MASK;
      if (wr_im) int_mask_reg <= reg_wdata & `CDR_INT_MASK_BITS;
      int_stat_reg <= int_stat_next;
    end
  end

  // Host write takes priority over a same-cycle advance from the text writer
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      txt_x_low_reg <= `CDR_RST_BYTE;
      txt_x_high_reg <= `CDR_RST_BYTE;
      txt_y_low_reg <= `CDR_RST_BYTE;
      txt_y_high_reg <= `CDR_RST_BYTE;
    end else begin
      if (wr_xl) txt_x_low_reg <= reg_wdata;
      else if (text_adv) txt_x_low_reg <= text_pos_new.x[7:0];
      if (wr_xh) txt_x_high_reg <= reg_wdata & `CDR_HI_MASK;
      else if (text_adv) txt_x_high_reg <= {3'b000, text_pos_new.x[12:8]};
      if (wr_yl) txt_y_low_reg <= reg_wdata;
      else if (text_adv) txt_y_low_reg <= text_pos_new.y[7:0];
      if (wr_yh) txt_y_high_reg <= reg_wdata & `CDR_HI_MASK;
      else if (text_adv) txt_y_high_reg <= {3'b000, text_pos_new.y[12:8]};
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= DRAW_IDLE;
      fill_reg <= 1'b0;
      triangle_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (wr_dc) begin
        fill_reg <= reg_wdata[`CDR_DRAW_FILL_BIT];
        triangle_reg <= reg_wdata[`CDR_DRAW_SHAPE_BIT];
      end
    end
  end

  // ****************************************************************
  // Outputs, all registered
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= `CDR_RST_BYTE;
      linear_mode <= 1'b0;
      mem_addr <= 32'h0000_0000;
      gfx_pos <= '0;
      text_pos <= '0;
      draw_start <= 1'b0;
      draw_stop <= 1'b0;
      draw_cmd <= '0;
      draw_busy <= 1'b0;
      irq <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : `CDR_RST_BYTE;
      linear_mode <= mode_linear;
      mem_addr <= mode_linear ? lin_addr : 32'h0000_0000;
      gfx_pos.x <= mode_linear ? '0 : blk_x;
      gfx_pos.y <= mode_linear ? '0 : blk_y;
      text_pos.x <= {txt_x_high_reg[4:0], txt_x_low_reg};
      text_pos.y <= {txt_y_high_reg[4:0], txt_y_low_reg};
      draw_start <= start_req && !busy_now;
      draw_stop <= stop_req && busy_now;
      if (start_req && !busy_now) begin
        draw_cmd.fill <= reg_wdata[`CDR_DRAW_FILL_BIT];
        draw_cmd.triangle <= reg_wdata[`CDR_DRAW_SHAPE_BIT];
      end
      draw_busy <= (state_next == DRAW_BUSY);
      irq <= |(int_stat_next & int_mask_reg);
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_start_busy;
    @(posedge clk_sys) disable iff (rst)
    (start_req && !busy_now) |=> busy_now;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("Start did not set busy");

  property p_stop_idle;
    @(posedge clk_sys) disable iff (rst)
    stop_req |=> !busy_now;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("Stop did not clear busy");

  property p_busy_read;
    @(posedge clk_sys) disable iff (rst)
    (reg_rd && hit(reg_addr, `CDR_OFS_DRAW_CTRL))
      |=> (reg_rdata[`CDR_DRAW_START_BIT] == $past(busy_now));
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("Busy bit read wrong");

  property p_lin_addr;
    @(posedge clk_sys) disable iff (rst)
    mode_linear |=> (mem_addr == $past(lin_addr));
  endproperty
  a_lin_addr: assert property (p_lin_addr) else $error("Linear address wrong");

  property p_blk_x;
    @(posedge clk_sys) disable iff (rst)
    !mode_linear |=> (gfx_pos.x == {$past(horiz_high_reg[4:0]), $past(horiz_low_reg)});
  endproperty
  a_blk_x: assert property (p_blk_x) else $error("Block X wrong");

  property p_blk_y;
    @(posedge clk_sys) disable iff (rst)
    !mode_linear |=> (gfx_pos.y == {$past(vert_high_reg[4:0]), $past(vert_low_reg)});
  endproperty
  a_blk_y: assert property (p_blk_y) else $error("Block Y wrong");

  property p_txt_adv;
    @(posedge clk_sys) disable iff (rst)
    (text_adv && !wr_xl) |=> ##1 (text_pos.x[7:0] == $past(text_pos_new.x[7:0], 2));
  endproperty
  a_txt_adv: assert property (p_txt_adv) else $error("Text cursor not updated");

  property p_hi_zero;
    @(posedge clk_sys) disable iff (rst)
    (reg_rd && hit(reg_addr, `CDR_OFS_TXT_Y_HIGH)) |=> (reg_rdata[7:5] == 3'b000);
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("Reserved bits nonzero");

  property p_fill_cmd;
    @(posedge clk_sys) disable iff (rst)
    (start_req && !busy_now) |=> (draw_cmd.fill == $past(reg_wdata[`CDR_DRAW_FILL_BIT]));
  endproperty
  a_fill_cmd: assert property (p_fill_cmd) else $error("Fill not passed");

  property p_lin_h_hi;
    @(posedge clk_sys) disable iff (rst)
    mode_linear |=> (mem_addr[15:13] == $past(horiz_high_reg[7:5]))
                    && (mem_addr[12:8] == $past(horiz_high_reg[4:0]));
  endproperty
  a_lin_h_hi: assert property (p_lin_h_hi) else $error("Linear address 15..8 wrong");

  property p_lin_v_lo;
    @(posedge clk_sys) disable iff (rst)
    mode_linear |=> (mem_addr[23:16] == $past(vert_low_reg));
  endproperty
  a_lin_v_lo: assert property (p_lin_v_lo) else $error("Linear address 23..16 wrong");

  property p_lin_v_top;
    @(posedge clk_sys) disable iff (rst)
    mode_linear |=> (mem_addr[31:29] == $past(vert_high_reg[7:5]));
  endproperty
  a_lin_v_top: assert property (p_lin_v_top) else $error("Linear address 31..29 wrong");

  property p_lin_v_mid;
    @(posedge clk_sys) disable iff (rst)
    mode_linear |=> (mem_addr[28:24] == $past(vert_high_reg[4:0]));
  endproperty
  a_lin_v_mid: assert property (p_lin_v_mid) else $error("Linear address 28..24 wrong");

  property p_mode_out;
    @(posedge clk_sys) disable iff (rst)
    1'b1 |=> (linear_mode == $past(mode_linear));
  endproperty
  a_mode_out: assert property (p_mode_out) else $error("Mode output wrong");

  property p_txt_x;
    @(posedge clk_sys) disable iff (rst)
    1'b1 |=> (text_pos.x == {$past(txt_x_high_reg[4:0]), $past(txt_x_low_reg)});
  endproperty
  a_txt_x: assert property (p_txt_x) else $error("Text X output wrong");

  property p_txt_y;
    @(posedge clk_sys) disable iff (rst)
    1'b1 |=> (text_pos.y == {$past(txt_y_high_reg[4:0]), $past(txt_y_low_reg)});
  endproperty
  a_txt_y: assert property (p_txt_y) else $error("Text Y output wrong");

  property p_txt_host;
    @(posedge clk_sys) disable iff (rst)
    wr_xl |=> (txt_x_low_reg == $past(reg_wdata));
  endproperty
  a_txt_host: assert property (p_txt_host) else $error("Host cursor write lost");

  property p_tri_cmd;
    @(posedge clk_sys) disable iff (rst)
    (start_req && !busy_now) |=> (draw_cmd.triangle == $past(reg_wdata[`CDR_DRAW_SHAPE_BIT]));
  endproperty
  a_tri_cmd: assert property (p_tri_cmd) else $error("Shape not passed");

  property p_start_pulse;
    @(posedge clk_sys) disable iff (rst)
    draw_start |=> !draw_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("Start pulse too long");

  property p_stop_out;
    @(posedge clk_sys) disable iff (rst)
    draw_stop |-> !busy_now;
  endproperty
  a_stop_out: assert property (p_stop_out) else $error("Stop pulse while busy");

  property p_busy_out;
    @(posedge clk_sys) disable iff (rst)
    draw_busy == busy_now;
  endproperty
  a_busy_out: assert property (p_busy_out) else $error("Busy output wrong");

  property p_done_idle;
    @(posedge clk_sys) disable iff (rst)
    done_evt |=> (!busy_now && int_stat_reg[0]);
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("Completion not seen");

  property p_irq_src;
    @(posedge clk_sys) disable iff (rst)
    irq |-> (|int_stat_reg);
  endproperty
  a_irq_src: assert property (p_irq_src) else $error("Interrupt without status");

  property p_rdata_idle;
    @(posedge clk_sys) disable iff (rst)
    !reg_rd |=> (reg_rdata == `CDR_RST_BYTE);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("Read data without read");

  property p_draw_rsvd;
    @(posedge clk_sys) disable iff (rst)
    (reg_rd && hit(reg_addr, `CDR_OFS_DRAW_CTRL)) |=> !(reg_rdata[6] || reg_rdata[0] || (|reg_rdata[4:2]));
  endproperty
  a_draw_rsvd: assert property (p_draw_rsvd) else $error("Draw reserved bits nonzero");

  property p_xhi_zero;
    @(posedge clk_sys) disable iff (rst)
    (reg_rd && hit(reg_addr, `CDR_OFS_TXT_X_HIGH)) |=> (reg_rdata[7:5] == 3'b000);
  endproperty
  a_xhi_zero: assert property (p_xhi_zero) else $error("Reserved bits nonzero");

  c_draw_done: cover property (@(posedge clk_sys) disable iff (rst) done_evt);
  c_draw_stop: cover property (@(posedge clk_sys) disable iff (rst) stop_req && busy_now);
  c_lin_mode: cover property (@(posedge clk_sys) disable iff (rst) mode_linear && wr_vh);
  c_irq: cover property (@(posedge clk_sys) disable iff (rst) irq);
  c_fill: cover property (@(posedge clk_sys) disable iff (rst) draw_start && draw_cmd.fill);

endmodule : cursor_draw_regs

// ### verif/cursor_draw_regs_bench.sv
// Self-checking bench for the cursor, position and draw control register group.
// Assumes the host port, text writer and draw engine are all played by this bench.
`timescale 1ns/1ps
`include "cursor_draw_cfg.svh"
module cursor_draw_regs_bench;
  import cursor_draw_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic text_adv = 1'b0;
  coord_t text_pos_new = '0;
  logic draw_done = 1'b0;
  logic [7:0] reg_rdata;
  logic linear_mode;
  logic [31:0] mem_addr;
  coord_t gfx_pos;
  coord_t text_pos;
  logic draw_start;
  logic draw_stop;
  draw_cmd_t draw_cmd;
  logic draw_busy;
  logic irq;
  int fail_count = 0;
  int cmp_count = 0;
  int cycles = 0;

  cursor_draw_regs u_cursor_draw_regs (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .linear_mode(linear_mode), .mem_addr(mem_addr), .gfx_pos(gfx_pos), .text_pos(text_pos),
    .text_adv(text_adv), .text_pos_new(text_pos_new), .draw_start(draw_start),
    .draw_stop(draw_stop), .draw_cmd(draw_cmd), .draw_done(draw_done),
    .draw_busy(draw_busy), .irq(irq));

  // ****************************************
  // Clock, timeout and report
  // ****************************************
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Whole run is about a hundred cycles; ceiling leaves ample slack
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count = fail_count + 1;
      close_out();
    end
  end

  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // ****************************************
  // Host port and far-side pulses
  // ****************************************
  // Outputs are checked 1 ns after the edge that took the request
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(d, exp);
  endtask : rd_chk

  task automatic pulse_done();
    @(posedge clk_sys);
    draw_done <= 1'b1;
    @(posedge clk_sys);
    draw_done <= 1'b0;
    #1;
  endtask : pulse_done

  // Position and cursor outputs lag their registers by one more edge
  task automatic settle();
    @(posedge clk_sys);
    #1;
  endtask : settle

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    for (int a = 8'h5f; a <= 8'h67; a++) rd_chk(a[7:0], 8'h00);
    for (int a = 8'h70; a <= 8'h72; a++) rd_chk(a[7:0], 8'h00);
    check({draw_busy, irq, linear_mode}, 3'b000);
    check(mem_addr, 32'h0);
    check(text_pos, 26'h0);
    // Linear canvas address assembly; canvas set up before any position write
    wr(`CDR_OFS_MODE, 8'h04);
    settle();
    check(linear_mode, 1'b1);
    wr(`CDR_OFS_HORIZ_LOW, 8'ha5);
    wr(`CDR_OFS_HORIZ_HIGH, 8'he3);
    wr(`CDR_OFS_VERT_LOW, 8'h5c);
    wr(`CDR_OFS_VERT_HIGH, 8'hb7);
    settle();
    check(mem_addr, 32'hb75ce3a5);
    check(gfx_pos, 26'h0);
    rd_chk(`CDR_OFS_HORIZ_HIGH, 8'he3);
    rd_chk(`CDR_OFS_VERT_HIGH, 8'hb7);
    // Block canvas keeps only the low five high bits
    wr(`CDR_OFS_MODE, 8'h00);
    settle();
    check(linear_mode, 1'b0);
    check(gfx_pos.x, 32'h03a5);
    check(gfx_pos.y, 32'h175c);
    check(mem_addr, 32'h0);
    // Text cursor set by host, then moved by the text writer; reserved bits stay zero
    wr(`CDR_OFS_TXT_X_LOW, 8'h12);
    wr(`CDR_OFS_TXT_X_HIGH, 8'h1f);
    wr(`CDR_OFS_TXT_Y_LOW, 8'h34);
    wr(`CDR_OFS_TXT_Y_HIGH, 8'h0a);
    settle();
    check(text_pos, {13'h1f12, 13'h0a34});
    rd_chk(`CDR_OFS_TXT_X_HIGH, 8'h1f);
    rd_chk(`CDR_OFS_TXT_Y_HIGH, 8'h0a);
    @(posedge clk_sys);
    text_adv <= 1'b1;
    text_pos_new <= {13'h0abc, 13'h1def};
    @(posedge clk_sys);
    text_adv <= 1'b0;
    @(posedge clk_sys);
    #1;
    check(text_pos, {13'h0abc, 13'h1def});
    rd_chk(`CDR_OFS_TXT_X_LOW, 8'hbc);
    rd_chk(`CDR_OFS_TXT_X_HIGH, 8'h0a);
    rd_chk(`CDR_OFS_TXT_Y_LOW, 8'hef);
    rd_chk(`CDR_OFS_TXT_Y_HIGH, 8'h1d);
    // Filled triangle, masked completion, then unmasked
    wr(`CDR_OFS_DRAW_CTRL, 8'ha2);
    check({draw_start, draw_busy, draw_cmd}, 4'b1111);
    rd_chk(`CDR_OFS_DRAW_CTRL, 8'ha2);
    wr(`CDR_OFS_DRAW_CTRL, 8'ha2);
    check({draw_start, draw_busy}, 2'b01);
    pulse_done();
    check(draw_busy, 1'b0);
    rd_chk(`CDR_OFS_DRAW_CTRL, 8'h22);
    rd_chk(`CDR_OFS_INT_STAT, 8'h01);
    check(irq, 1'b0);
    wr(`CDR_OFS_INT_MASK, 8'h01);
    rd_chk(`CDR_OFS_INT_MASK, 8'h01);
    check(irq, 1'b1);
    wr(`CDR_OFS_INT_STAT, 8'h01);
    rd_chk(`CDR_OFS_INT_STAT, 8'h00);
    check(irq, 1'b0);
    // Plain line, stopped by host before completion
    wr(`CDR_OFS_DRAW_CTRL, 8'h80);
    check({draw_start, draw_busy, draw_cmd}, 4'b1100);
    wr(`CDR_OFS_DRAW_CTRL, 8'h00);
    check({draw_stop, draw_busy}, 2'b10);
    rd_chk(`CDR_OFS_DRAW_CTRL, 8'h00);
    // Unmapped place reads zero and ignores writes
    wr(8'h80, 8'h5a);
    rd_chk(8'h80, 8'h00);
    close_out();
  end
endmodule : cursor_draw_regs_bench
